// file: src/sdfb_pkg.sv
package sdfb_pkg;

	// Array geometry.
	localparam int ROW_W     = 11;
	localparam int COL_W     = 8;
	localparam int BANK_W    = 2;
	localparam int NUM_BANKS = 4;
	localparam int DATA_W    = 32;
	localparam int LANES     = 4;
	localparam int MODE_W    = 11;
	localparam int MEM_AW    = BANK_W + ROW_W + COL_W;

	// Address bit that widens a precharge or requests auto-precharge.
	localparam int PRE_SCOPE_BIT = 10;

	// Mode register field positions.
	localparam int BL_LSB  = 0;
	localparam int BT_BIT  = 3;
	localparam int CL_LSB  = 4;
	localparam int WBM_BIT = 9;

	// Mode register encodings.
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_3    = 3'h3;

	// Wrap masks for each burst length; a mask is also the beat count minus one, except for a page burst, which runs until stopped.
	localparam logic [7:0] WRAP_1    = 8'h00;
	localparam logic [7:0] WRAP_2    = 8'h01;
	localparam logic [7:0] WRAP_4    = 8'h03;
	localparam logic [7:0] WRAP_8    = 8'h07;
	localparam logic [7:0] WRAP_PAGE = 8'hFF;

	// Mode after reset: burst of one, sequential, CAS latency two.
	localparam logic [10:0] MODE_RST = 11'h020;

	// Command code is {ras_n, cas_n, we_n}.
	typedef enum logic [2:0] {
		CMD_MRS = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR  = 3'h4,
		CMD_RD  = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} sdfb_cmd_e;

	typedef enum logic [3:0] {
		PS_RUN  = 4'h1,
		PS_PDN  = 4'h2,
		PS_SUSP = 4'h4,
		PS_SREF = 4'h8
	} sdfb_ps_e;

	// Spacings the controller keeps; the device does not check them.
	localparam int CLK_PS     = 4000;
	localparam int T_RC_PS    = 60000;
	localparam int ACTIVATE_TO_COLUMN_MIN_PS   = 18000;
	localparam int T_RP_PS    = 18000;
	localparam int ACTIVATE_SPACING_OTHER_BANK_PS   = 12000;
	localparam int T_RAS_PS   = 42000;
	localparam int REFRESH_INTERVAL_AVG_NS  = 15600;
	localparam int RC_CYC     = (T_RC_PS + CLK_PS - 1) / CLK_PS;
	localparam int RCD_CYC    = (ACTIVATE_TO_COLUMN_MIN_PS + CLK_PS - 1) / CLK_PS;
	localparam int RP_CYC     = (T_RP_PS + CLK_PS - 1) / CLK_PS;
	localparam int RRD_CYC    = (ACTIVATE_SPACING_OTHER_BANK_PS + CLK_PS - 1) / CLK_PS;
	localparam int RAS_CYC    = (T_RAS_PS + CLK_PS - 1) / CLK_PS;
	localparam int REFI_CYC   = (REFRESH_INTERVAL_AVG_NS * 1000) / CLK_PS;

endpackage

// file: src/sdfb_mem.sv
module sdfb_mem (
	// Clock
	input  wire logic                             clk_i,
	// Access
	input  wire logic                             en_i,
	input  wire logic                             we_i,
	input  wire logic [sdfb_pkg::LANES-1:0]       be_i,
	input  wire logic [sdfb_pkg::MEM_AW-1:0]      addr_i,
	input  wire logic [sdfb_pkg::DATA_W-1:0]      wdata_i,
	output logic      [sdfb_pkg::DATA_W-1:0]      rdata_o
);

	logic [7:0] ram [sdfb_pkg::LANES][0:(2**sdfb_pkg::MEM_AW)-1];

	// One byte array per lane, so each lane's writes belong to a single process.
	for (genvar l = 0; l < sdfb_pkg::LANES; l++)
	begin : g_lane
		always_ff @(posedge clk_i)
		begin
			if (en_i && we_i && be_i[l])
				ram[l][addr_i] <= wdata_i[l*8 +: 8];
		end
		// Read data holds while the port is idle.
		always_ff @(posedge clk_i)
		begin
			if (en_i && !we_i)
				rdata_o[l*8 +: 8] <= ram[l][addr_i];
		end
	end

endmodule

// file: src/sdfb_core.sv
module sdfb_core (
	// Clock and reset
	input  wire logic                              clk_sys_i,
	input  wire logic                              srst_i,
	// Command pins
	input  wire logic                              cke_i,
	input  wire logic                              cs_n_i,
	input  wire logic                              ras_n_i,
	input  wire logic                              cas_n_i,
	input  wire logic                              we_n_i,
	input  wire logic [sdfb_pkg::BANK_W-1:0]       bank_select_bits_i,
	input  wire logic [sdfb_pkg::ROW_W-1:0]        addr_i,
	input  wire logic [sdfb_pkg::LANES-1:0]        byte_lane_mask_i,
	// Data pins
	input  wire logic [sdfb_pkg::DATA_W-1:0]       dq_i,
	output logic      [sdfb_pkg::DATA_W-1:0]       dq_o,
	output logic      [sdfb_pkg::LANES-1:0]        dq_oe_o,
	// Status
	output logic      [sdfb_pkg::NUM_BANKS-1:0]    bank_open_o,
	output logic                                   power_down_o,
	output logic                                   clock_suspend_o,
	output logic                                   self_refresh_o
);

	logic                  cke_q;
	sdfb_pkg::sdfb_ps_e    ps_q;
	sdfb_pkg::sdfb_ps_e    ps_d;
	logic [10:0]           mode_q;
	logic [3:0]            open_q;
	logic [10:0]           row_q [sdfb_pkg::NUM_BANKS];
	logic                  bst_act_q;
	logic                  bst_wr_q;
	logic                  bst_ap_q;
	logic                  bst_page_q;
	logic                  bst_bt_q;
	logic [1:0]            bst_bank_q;
	logic [7:0]            bst_col_q;
	logic [7:0]            bst_idx_q;
	logic [7:0]            bst_left_q;
	logic [7:0]            bst_mask_q;
	logic                  rv0_q;
	logic                  rv1_q;
	logic [3:0]            mask_q;
	logic [31:0]           rd1_q;
	logic [31:0]           mem_rd_w;

	// An edge counts only when clock enable was high one edge earlier.
	wire logic en_w = cke_q;
	wire logic run_w = (ps_q == sdfb_pkg::PS_RUN);

	// Command decode.
	sdfb_pkg::sdfb_cmd_e cmd_w;
	assign cmd_w = sdfb_pkg::sdfb_cmd_e'({ras_n_i, cas_n_i, we_n_i});
	wire logic cmd_ok_w = en_w & ~cs_n_i & run_w;
	wire logic is_act_w = cmd_ok_w & (cmd_w == sdfb_pkg::CMD_ACT);
	wire logic is_rd_w = cmd_ok_w & (cmd_w == sdfb_pkg::CMD_RD);
	wire logic is_wr_w = cmd_ok_w & (cmd_w == sdfb_pkg::CMD_WR);
	wire logic is_pre_w = cmd_ok_w & (cmd_w == sdfb_pkg::CMD_PRE);
	wire logic is_mrs_w = cmd_ok_w & (cmd_w == sdfb_pkg::CMD_MRS);
	wire logic is_ref_w = cmd_ok_w & (cmd_w == sdfb_pkg::CMD_REF);
	wire logic is_bst_w = cmd_ok_w & (cmd_w == sdfb_pkg::CMD_BST);
	wire logic col_cmd_w = is_rd_w | is_wr_w;
	wire logic scope_w = addr_i[sdfb_pkg::PRE_SCOPE_BIT];
	wire logic pre_all_w = is_pre_w & scope_w;
	wire logic sref_w = is_ref_w & ~cke_i;
	wire logic [7:0] cmd_col_w = addr_i[sdfb_pkg::COL_W-1:0];

	// Mode fields.
	wire logic [2:0] bl_w = mode_q[sdfb_pkg::BL_LSB +: 3];
	wire logic bt_w = mode_q[sdfb_pkg::BT_BIT];
	wire logic cl3_w = (mode_q[sdfb_pkg::CL_LSB +: 3] == sdfb_pkg::CL_3);
	wire logic wbm_w = mode_q[sdfb_pkg::WBM_BIT];
	wire logic page_w = (bl_w == sdfb_pkg::BL_PAGE);
	// Reserved lengths fall back to a single beat.
	wire logic [7:0] wrap_w = (bl_w == sdfb_pkg::BL_2) ? sdfb_pkg::WRAP_2 :
		(bl_w == sdfb_pkg::BL_4) ? sdfb_pkg::WRAP_4 :
		(bl_w == sdfb_pkg::BL_8) ? sdfb_pkg::WRAP_8 :
		page_w ? sdfb_pkg::WRAP_PAGE : sdfb_pkg::WRAP_1;
	wire logic single_w = is_wr_w & wbm_w;
	wire logic [7:0] new_left_w = single_w ? sdfb_pkg::WRAP_1 : wrap_w;

	// Burst engine: beat zero is taken from the pins, later beats from the counter.
	wire logic hit_pre_w = is_pre_w & (scope_w | (bank_select_bits_i == bst_bank_q));
	wire logic stop_w = (is_bst_w & ~bst_ap_q) | hit_pre_w;
	wire logic cont_w = bst_act_q & en_w & ~col_cmd_w & ~stop_w;
	wire logic last_w = cont_w & ~bst_page_q & (bst_left_q == 8'h01);
	wire logic [7:0] seq_col_w = 8'(bst_col_q + bst_idx_q);
	wire logic [7:0] ilv_col_w = bst_col_q ^ bst_idx_q;
	wire logic [7:0] burst_col_w = (bst_col_q & ~bst_mask_q) |
		((bst_bt_q ? ilv_col_w : seq_col_w) & bst_mask_q);
	wire logic beat_w = col_cmd_w | cont_w;
	wire logic beat_wr_w = col_cmd_w ? is_wr_w : bst_wr_q;
	wire logic [1:0] beat_bank_w = col_cmd_w ? bank_select_bits_i : bst_bank_q;
	wire logic [7:0] beat_col_w = col_cmd_w ? cmd_col_w : burst_col_w;
	wire logic [20:0] mem_addr_w = {beat_bank_w, row_q[beat_bank_w], beat_col_w};
	wire logic mem_en_w = en_w & beat_w;
	wire logic [3:0] mem_be_w = ~byte_lane_mask_i;

	// Auto-precharge closes the bank when its last beat is transferred.
	wire logic ap_close_w = (col_cmd_w & scope_w & (new_left_w == sdfb_pkg::WRAP_1)) |
		(last_w & bst_ap_q);
	wire logic [1:0] ap_bank_w = col_cmd_w ? bank_select_bits_i : bst_bank_q;
	wire logic busy_w = bst_act_q | rv0_q | rv1_q;

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			cke_q <= 1'b1;
		else
			cke_q <= cke_i;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			mode_q <= sdfb_pkg::MODE_RST;
		else if (is_mrs_w)
			mode_q <= addr_i;
	end

	// Per-bank row state; banks open and close independently.
	for (genvar b = 0; b < sdfb_pkg::NUM_BANKS; b++)
	begin : g_bank
		wire logic sel_w = (bank_select_bits_i == 2'(b));
		wire logic close_w = (is_pre_w & (scope_w | sel_w)) |
			(ap_close_w & (ap_bank_w == 2'(b)));
		always_ff @(posedge clk_sys_i)
		begin
			if (srst_i)
				open_q[b] <= 1'b0;
			else if (is_act_w && sel_w)
				open_q[b] <= 1'b1;
			else if (close_w)
				open_q[b] <= 1'b0;
		end
		always_ff @(posedge clk_sys_i)
		begin
			if (is_act_w && sel_w)
				row_q[b] <= addr_i;
		end
	end

	// A column command to a closed bank reads or writes whatever row was last held.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			bst_act_q <= 1'b0;
			bst_wr_q <= 1'b0;
			bst_ap_q <= 1'b0;
			bst_page_q <= 1'b0;
			bst_bt_q <= 1'b0;
			bst_bank_q <= 2'h0;
			bst_col_q <= 8'h00;
			bst_idx_q <= 8'h00;
			bst_left_q <= 8'h00;
			bst_mask_q <= 8'h00;
		end
		else if (col_cmd_w)
		begin
			bst_act_q <= (new_left_w != sdfb_pkg::WRAP_1);
			bst_wr_q <= is_wr_w;
			bst_ap_q <= scope_w;
			bst_page_q <= page_w & ~single_w;
			bst_bt_q <= bt_w & ~page_w;
			bst_bank_q <= bank_select_bits_i;
			bst_col_q <= cmd_col_w;
			bst_idx_q <= 8'h01;
			bst_left_q <= new_left_w;
			bst_mask_q <= new_left_w;
		end
		else if (stop_w || last_w)
			bst_act_q <= 1'b0;
		else if (cont_w)
		begin
			bst_idx_q <= 8'(bst_idx_q + 8'h01);
			if (!bst_page_q)
				bst_left_q <= 8'(bst_left_q - 8'h01);
		end
	end

	// Power states; exit takes one edge with clock enable high.
	always_comb
	begin
		ps_d = ps_q;
		case (ps_q)
			sdfb_pkg::PS_RUN:
				if (en_w && !cke_i)
					ps_d = sref_w ? sdfb_pkg::PS_SREF :
						busy_w ? sdfb_pkg::PS_SUSP : sdfb_pkg::PS_PDN;
			sdfb_pkg::PS_PDN, sdfb_pkg::PS_SUSP, sdfb_pkg::PS_SREF:
				if (cke_i)
					ps_d = sdfb_pkg::PS_RUN;
			default:
				ps_d = sdfb_pkg::PS_RUN;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			ps_q <= sdfb_pkg::PS_RUN;
		else
			ps_q <= ps_d;
	end

	sdfb_mem u_mem (
		.clk_i   (clk_sys_i),
		.en_i    (mem_en_w),
		.we_i    (beat_wr_w),
		.be_i    (mem_be_w),
		.addr_i  (mem_addr_w),
		.wdata_i (dq_i),
		.rdata_o (mem_rd_w)
	);

	// The memory adds one stage, so latency two takes its output straight to
	// the pin register and latency three inserts one more. A suspended edge
	// freezes the whole pipeline, which holds the data on the pins.
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			rv0_q <= 1'b0;
			rv1_q <= 1'b0;
			mask_q <= 4'hF;
			rd1_q <= 32'h0000_0000;
			dq_o <= 32'h0000_0000;
			dq_oe_o <= 4'h0;
		end
		else if (en_w)
		begin
			rv0_q <= beat_w & ~beat_wr_w;
			rv1_q <= rv0_q;
			mask_q <= byte_lane_mask_i;
			rd1_q <= mem_rd_w;
			dq_o <= cl3_w ? rd1_q : mem_rd_w;
			dq_oe_o <= {4{cl3_w ? rv1_q : rv0_q}} & ~mask_q;
		end
	end

	assign bank_open_o = open_q;
	assign power_down_o = ps_q[1];
	assign clock_suspend_o = ps_q[2];
	assign self_refresh_o = ps_q[3];

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	property p_cl2_read;
		(is_rd_w && !cl3_w && cke_i) |-> ##2 dq_oe_o == ~$past(byte_lane_mask_i, 2);
	endproperty
	a_cl2_read: assert property (p_cl2_read) else $error("latency two read late");
	property p_cl3_read;
		(is_rd_w && cl3_w && cke_i) ##1 (cke_i && !is_mrs_w)
			|=> ##1 dq_oe_o == ~$past(byte_lane_mask_i, 2);
	endproperty
	a_cl3_read: assert property (p_cl3_read) else $error("latency three read wrong");
	property p_mask_float;
		(en_w && cke_i && byte_lane_mask_i[0]) |=> ##1 !dq_oe_o[0];
	endproperty
	a_mask_float: assert property (p_mask_float) else $error("masked lane driven");
	property p_wr_block;
		(mem_en_w && beat_wr_w && byte_lane_mask_i[0]) |=>
			u_mem.ram[0][$past(mem_addr_w)] == $past(u_mem.ram[0][mem_addr_w]);
	endproperty
	a_wr_block: assert property (p_wr_block) else $error("masked lane written");
	property p_cs_hold;
		(cs_n_i && cont_w && !last_w && !bst_page_q) |=>
			bst_act_q && bst_left_q == 8'($past(bst_left_q) - 8'h01);
	endproperty
	a_cs_hold: assert property (p_cs_hold) else $error("burst stalled by deselect");
	property p_pre_all;
		pre_all_w |=> open_q == 4'h0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");
	property p_pre_one;
		(is_pre_w && !scope_w && !ap_close_w) |=>
			open_q == ($past(open_q) & ~(4'h1 << $past(bank_select_bits_i)));
	endproperty
	a_pre_one: assert property (p_pre_one) else $error("single precharge scope wrong");
	property p_activate;
		is_act_w |=> open_q[$past(bank_select_bits_i)] &&
			row_q[$past(bank_select_bits_i)] == $past(addr_i);
	endproperty
	a_activate: assert property (p_activate) else $error("activate did not open row");
	property p_bl4;
		(is_rd_w && bl_w == sdfb_pkg::BL_4) |=> bst_act_q && bst_left_q == 8'h03;
	endproperty
	a_bl4: assert property (p_bl4) else $error("burst of four miscounted");
	property p_single_wr;
		is_wr_w && wbm_w |=> !bst_act_q;
	endproperty
	a_single_wr: assert property (p_single_wr) else $error("single write kept bursting");
	property p_autopre;
		(is_rd_w && scope_w && bl_w == 3'h0) |=> !open_q[$past(bank_select_bits_i)];
	endproperty
	a_autopre: assert property (p_autopre) else $error("auto-precharge left bank open");
	property p_sref;
		(run_w && sref_w) |=> ps_q == sdfb_pkg::PS_SREF;
	endproperty
	a_sref: assert property (p_sref) else $error("self-refresh not entered");

	c_read: cover property (is_rd_w ##[1:3] dq_oe_o != 4'h0);
	c_page: cover property (bst_act_q && bst_page_q && bst_idx_q == 8'h00);
	c_sref: cover property (ps_q == sdfb_pkg::PS_SREF ##1 ps_q == sdfb_pkg::PS_RUN);
	c_susp: cover property (ps_q == sdfb_pkg::PS_SUSP && bst_act_q);

endmodule

// file: sim/sdfb_ctrl_model.sv
module sdfb_ctrl_model #(
	parameter int INIT_WAIT = 50000,
	parameter int SLACK     = 0
) (
	// Clock
	input  wire logic        clk_i,
	// Command pins
	output logic             cke_o,
	output logic             cs_n_o,
	output logic             ras_n_o,
	output logic             cas_n_o,
	output logic             we_n_o,
	output logic [1:0]       bank_o,
	output logic [10:0]      addr_o,
	output logic [3:0]       mask_o,
	// Write data
	output logic [31:0]      dq_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		{ras_n_o, cas_n_o, we_n_o} = sdfb_pkg::CMD_NOP;
		bank_o = 2'h0;
		addr_o = 11'h000;
		mask_o = 4'hF;
		dq_o = 32'h0000_0000;
	end

	// Pins change at the falling edge and the device takes them at the next rising edge.
	task automatic drive(input logic cs_n, input sdfb_pkg::sdfb_cmd_e c, input logic [1:0] b,
		input logic [10:0] a, input logic [3:0] m, input logic [31:0] d, input logic wr,
		input logic k);
		@(negedge clk_i);
		cke_o = k;
		cs_n_o = cs_n;
		{ras_n_o, cas_n_o, we_n_o} = c;
		bank_o = b;
		addr_o = a;
		mask_o = m;
		// A released data bus must not keep its last value, so it toggles.
		dq_o = wr ? d : ~dq_o;
	endtask

	task automatic nop(input int n);
		repeat (n) drive(1'b0, sdfb_pkg::CMD_NOP, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
	endtask

	// Waiting out the minimum row-open time here also covers the column delay.
	task automatic act(input logic [1:0] b, input logic [10:0] row);
		drive(1'b0, sdfb_pkg::CMD_ACT, b, row, 4'h0, 32'h0, 1'b0, 1'b1);
		nop(sdfb_pkg::RAS_CYC + SLACK);
	endtask

	task automatic pre(input logic [1:0] b, input logic all);
		drive(1'b0, sdfb_pkg::CMD_PRE, b, {all, 10'h000}, 4'h0, 32'h0, 1'b0, 1'b1);
		nop(sdfb_pkg::RP_CYC + SLACK);
	endtask

	task automatic mode(input logic [10:0] v);
		drive(1'b0, sdfb_pkg::CMD_MRS, 2'h0, v, 4'h0, 32'h0, 1'b0, 1'b1);
		nop(2);
	endtask

	// A run ends long before one refresh interval, so start-up refreshes suffice.
	task automatic init;
		repeat (INIT_WAIT) drive(1'b0, sdfb_pkg::CMD_NOP, 2'h0, 11'h000, 4'hF, 32'h0, 1'b0,
			1'b1);
		pre(2'h0, 1'b1);
		repeat (8)
		begin
			drive(1'b0, sdfb_pkg::CMD_REF, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
			nop(sdfb_pkg::RC_CYC);
		end
	endtask
endmodule

// file: sim/sdfb_core_tb.sv
module sdfb_core_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam sdfb_pkg::sdfb_cmd_e RD = sdfb_pkg::CMD_RD;
	localparam sdfb_pkg::sdfb_cmd_e WR = sdfb_pkg::CMD_WR;
	localparam sdfb_pkg::sdfb_cmd_e NOP = sdfb_pkg::CMD_NOP;

	logic        clk_sys_i;
	logic        srst_i;
	logic        cke, cs_n, ras_n, cas_n, we_n;
	logic [1:0]  bank;
	logic [10:0] addr;
	logic [3:0]  mask, dq_oe_o, bank_open_o, pwr;
	logic [31:0] dq_i, dq_o, mixed;
	logic        power_down_o, clock_suspend_o, self_refresh_o;
	int          failures;
	int          checks_done;

	assign pwr = {1'b0, power_down_o, clock_suspend_o, self_refresh_o};

	sdfb_ctrl_model #(.INIT_WAIT(250), .SLACK(2)) ctrl (.clk_i(clk_sys_i), .cke_o(cke),
		.cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .bank_o(bank),
		.addr_o(addr), .mask_o(mask), .dq_o(dq_i));

	sdfb_core dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cke_i(cke), .cs_n_i(cs_n),
		.ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .bank_select_bits_i(bank),
		.addr_i(addr), .byte_lane_mask_i(mask), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
		.bank_open_o(bank_open_o), .power_down_o(power_down_o),
		.clock_suspend_o(clock_suspend_o), .self_refresh_o(self_refresh_o));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] pat(input logic [7:0] s, input logic [7:0] i);
		return {s, 8'h5A, ~s, i};
	endfunction

	function automatic logic [10:0] md(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
		input logic wbm);
		return {1'b0, wbm, 2'b00, cl, bt, bl};
	endfunction

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t data %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t flags %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [1:0] b, input logic [10:0] col, input logic [31:0] d[$],
		input logic [3:0] m[$]);
		for (int i = 0; i < d.size(); i++)
			ctrl.drive(1'b0, i == 0 ? WR : NOP, b, col, m[i], d[i], 1'b1, 1'b1);
		ctrl.nop(1);
	endtask

	// Deselected cycles carry a read code that would cut the burst if decoded.
	task automatic rd(input logic [1:0] b, input logic [10:0] cols[$], input int cl,
		input logic [3:0] m, input logic desel, input logic [31:0] exp[$]);
		logic [3:0]  oe;
		logic [3:0]  mk;
		logic [31:0] lanes;
		for (int j = 0; j <= cl + exp.size(); j++)
		begin
			// The mask for the first beat goes out two edges before that beat shows.
			mk = (j == cl - 2) ? m : 4'h0;
			if (j < cols.size())
				ctrl.drive(1'b0, RD, b, cols[j], mk, 32'h0, 1'b0, 1'b1);
			else
				ctrl.drive(desel, desel ? RD : NOP, b, 11'h000, mk, 32'h0, 1'b0, 1'b1);
			if (j >= cl)
			begin
				oe = (j == cl + exp.size()) ? 4'h0 : ((j == cl) ? ~m : 4'hF);
				lanes = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
				chk_bits(dq_oe_o, oe);
				if (j < cl + exp.size())
					chk_data(dq_o & lanes, exp[j - cl] & lanes);
			end
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		failures++;
		finish_test();
	end

	// Only banks with an open row are read or written.
	initial
	begin
		failures = 0;
		checks_done = 0;
		srst_i = 1'b1;
		mixed = (pat(2, 1) & 32'hFFFF_FF00) | (pat(1, 1) & 32'h0000_00FF);
		repeat (4) @(negedge clk_sys_i);
		srst_i = 1'b0;
		ctrl.init();
		chk_bits(bank_open_o, 4'h0);
		ctrl.mode(md(sdfb_pkg::BL_4, 1'b0, 3'h2, 1'b0));
		ctrl.act(2'h1, 11'h5A5);
		chk_bits(bank_open_o, 4'h2);
		wr(2'h1, 11'h006, '{pat(1, 0), pat(1, 1), pat(1, 2), pat(1, 3)}, '{0, 0, 0, 0});
		rd(2'h1, '{11'h005}, 2, 4'h0, 1'b1, '{pat(1, 3), pat(1, 0), pat(1, 1), pat(1, 2)});
		wr(2'h1, 11'h006, '{pat(2, 0), pat(2, 1), pat(2, 2), pat(2, 3)}, '{0, 1, 0, 0});
		ctrl.pre(2'h1, 1'b0);
		chk_bits(bank_open_o, 4'h0);
		ctrl.mode(md(sdfb_pkg::BL_4, 1'b1, sdfb_pkg::CL_3, 1'b0));
		ctrl.act(2'h1, 11'h5A5);
		rd(2'h1, '{11'h005}, 3, 4'h6, 1'b0, '{pat(2, 3), pat(2, 2), mixed, pat(2, 0)});
		ctrl.pre(2'h0, 1'b1);
		ctrl.mode(md(3'h0, 1'b0, 3'h2, 1'b0));
		ctrl.act(2'h1, 11'h5A5);
		rd(2'h1, '{4, 5, 6, 11'h407}, 2, 4'h0, 1'b0,
			'{pat(2, 2), pat(2, 3), pat(2, 0), mixed});
		chk_bits(bank_open_o, 4'h0);
		ctrl.pre(2'h0, 1'b1);
		ctrl.mode(md(sdfb_pkg::BL_4, 1'b0, 3'h2, 1'b1));
		ctrl.act(2'h1, 11'h5A5);
		wr(2'h1, 11'h006, '{pat(3, 0), pat(3, 1), pat(3, 2), pat(3, 3)}, '{0, 0, 0, 0});
		rd(2'h1, '{11'h406}, 2, 4'h0, 1'b0, '{pat(3, 0), mixed, pat(2, 2), pat(2, 3)});
		ctrl.nop(sdfb_pkg::RP_CYC);
		chk_bits(bank_open_o, 4'h0);
		ctrl.act(2'h0, 11'h001);
		ctrl.act(2'h2, 11'h002);
		chk_bits(bank_open_o, 4'h5);
		ctrl.pre(2'h0, 1'b0);
		chk_bits(bank_open_o, 4'h4);
		ctrl.act(2'h3, 11'h7FF);
		chk_bits(bank_open_o, 4'hC);
		ctrl.pre(2'h1, 1'b1);
		chk_bits(bank_open_o, 4'h0);
		repeat (3) ctrl.drive(1'b0, NOP, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b0);
		chk_bits(pwr, 4'h4);
		ctrl.nop(3);
		chk_bits(pwr, 4'h0);
		ctrl.drive(1'b0, sdfb_pkg::CMD_REF, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b0);
		repeat (2) ctrl.drive(1'b1, NOP, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b0);
		chk_bits(pwr, 4'h1);
		ctrl.nop(sdfb_pkg::RC_CYC + 2);
		chk_bits(pwr, 4'h0);
		ctrl.mode(md(sdfb_pkg::BL_8, 1'b0, 3'h2, 1'b0));
		ctrl.act(2'h1, 11'h5A5);
		ctrl.drive(1'b0, RD, 2'h1, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
		repeat (2) ctrl.drive(1'b0, NOP, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b0);
		chk_bits(pwr, 4'h2);
		// Clock enable must be high one edge before the stop, or the stop is ignored.
		ctrl.nop(1);
		ctrl.drive(1'b0, sdfb_pkg::CMD_BST, 2'h0, 11'h000, 4'h0, 32'h0, 1'b0, 1'b1);
		ctrl.nop(2);
		chk_bits(dq_oe_o, 4'h0);
		ctrl.nop(10);
		ctrl.pre(2'h0, 1'b1);
		finish_test();
	end
endmodule
